// *** rtl/pdm_cells.sv ***
`timescale 1ns/1ns
`default_nettype none
module pdm_cells (
	input  wire logic       core_clk, // clock
	input  wire logic       sys_rst,  // async reset
	input  wire logic       wr_en,    // mcu write this cycle
	input  wire logic [7:0] wr_data,  // mcu data
	input  wire logic [7:0] blk,      // load-block mask
	input  wire logic [7:0] logic_d,  // logic-array next value
	input  wire logic       logic_en, // logic-array clock enable
	output logic      [7:0] q         // cell outputs
);
	logic [7:0] q_nxt;
	always_comb begin
		q_nxt = q;
		if (logic_en)
			q_nxt = logic_d;
		if (wr_en)
			q_nxt = (q_nxt & blk) | (wr_data & ~blk);
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			q <= pdm_pkg::CELL_RST;
		else
			q <= q_nxt;
	end
endmodule // pdm_cells
`default_nettype wire

// *** rtl/pdm_pkg.sv ***
// Functional notes
// - input-mode read returns live pin level
// - output latch drives pins when enabled
// - output latch reads back written value
// - cell location reads outputs, masked write loads
// - load-block bit per cell, resets unblocked
// - input cells latch pins, feed logic, readable
// - driver status: 1 drives, 0 tri-stated
// - register availability differs per port
// - port D has four multipurpose pins
// - chip select high disables register block
// - ports F,G carry data in data-port mode
// - bank cells to A/B, selects to C/F
// - port A supports open-drain drive
// - port E shares pins with programming port
// - port F peripheral, reset pattern, address modes
// - direction 1 output; logic enable forces output
package pdm_pkg;
	localparam int PORTS   = 7;
	localparam int W       = 8;
	localparam int AW      = 8;
	localparam int DW      = 4;
	localparam int PA = 0;
	localparam int PB = 1;
	localparam int PC = 2;
	localparam int PD = 3;
	localparam int PE = 4;
	localparam int PF = 5;
	localparam int PG = 6;
	localparam logic [7:0] D_MASK = 8'h0f;
	localparam logic [7:0] ZERO8  = 8'h00;
	// register kind in addr[6:4], port in addr[2:0]
	localparam logic [2:0] K_PIN  = 3'h0;
	localparam logic [2:0] K_OUT  = 3'h1;
	localparam logic [2:0] K_CELL = 3'h2;
	localparam logic [2:0] K_BLK  = 3'h3;
	localparam logic [2:0] K_ICL  = 3'h4;
	localparam logic [2:0] K_DRV  = 3'h5;
	localparam logic [2:0] K_DIR  = 3'h6;
	localparam logic [2:0] K_MODE = 3'h7;
	localparam int KIND_LSB = 4;
	localparam int KIND_MSB = 6;
	localparam int PORT_MSB = 2;
	localparam logic [7:0] CELL_RST = 8'h00;
	localparam logic [7:0] BLK_RST  = 8'h00;
	// mode register bits (per port, meaning depends on port)
	localparam int M_OD    = 0;
	localparam int M_ALT   = 1;
	localparam int M_DATA  = 2;
	localparam int M_PERIPH= 3;
	localparam int M_RSTPAT= 4;
	localparam int M_JTAG  = 5;
	localparam int M_ADDR  = 6;
endpackage

// *** rtl/pdm_ports.sv ***
`timescale 1ns/1ns
`default_nettype none
module pdm_ports (
	input  wire logic        core_clk,       // clock
	input  wire logic        sys_rst,        // async reset
	input  wire logic        reg_cs,         // register block select
	input  wire logic        reg_wr,         // write strobe, one cycle
	input  wire logic        reg_rd,         // read strobe, one cycle
	input  wire logic [7:0]  reg_addr,       // register offset
	input  wire logic [7:0]  reg_wdata,      // write data
	output logic      [7:0]  reg_rdata,      // read data, registered
	input  wire logic        chip_sel_n_in,  // port D select pin, low selects
	input  wire logic [55:0] pin_in,         // pin levels, port n at [8n+7:8n]
	output logic      [55:0] pin_out,        // pin drive values
	output logic      [55:0] pin_oe,         // pin drive enables
	input  wire logic [7:0]  bank_a_cells_d, // bank A logic next values
	input  wire logic [7:0]  bank_b_cells_d, // bank B logic next values
	input  wire logic        cell_clk_en,    // macrocell clock enable
	input  wire logic [7:0]  input_cell_le,  // input cell latch enable A,B,C
	input  wire logic [31:0] logic_oe,       // logic enables A,B,C,F
	input  wire logic [7:0]  external_select_outputs, // select outputs
	input  wire logic [7:0]  addr_latch_lo,  // latched address low
	input  wire logic [7:0]  addr_latch_hi,  // latched address high
	input  wire logic [15:0] data_bus_out,   // data port drive
	input  wire logic        data_bus_oe,    // data port enable
	input  wire logic        periph_sel,     // peripheral mode select
	input  wire logic [7:0]  periph_data,    // peripheral data
	input  wire logic        mcu_reset,      // mcu in reset, no cycle
	input  wire logic [15:0] reset_pattern,  // reset drive pattern
	input  wire logic        jtag_active,    // programming port owns E
	input  wire logic [7:0]  jtag_out,       // programming port drive
	input  wire logic [7:0]  jtag_oe,        // programming port enable
	output logic      [23:0] input_cell_bus, // input cells to logic
	output logic      [55:0] pins_sync,      // synchronised pin levels
	output logic      [15:0] bank_cells      // macrocell outputs A,B
);
	logic [7:0] sy [pdm_pkg::PORTS];
	logic [7:0] out_r [pdm_pkg::PORTS];
	logic [7:0] out_nxt [pdm_pkg::PORTS];
	logic [7:0] dir_r [pdm_pkg::PORTS];
	logic [7:0] dir_nxt [pdm_pkg::PORTS];
	logic [7:0] mode_r [pdm_pkg::PORTS];
	logic [7:0] mode_nxt [pdm_pkg::PORTS];
	logic [7:0] blk_r [2];
	logic [7:0] blk_nxt [2];
	logic [7:0] icl_r [3];
	logic [7:0] icl_nxt [3];
	logic [7:0] cell_q [2];
	logic [7:0] drv [pdm_pkg::PORTS];
	logic [7:0] val [pdm_pkg::PORTS];
	logic [7:0] rdata_nxt;
	logic [7:0] sel_sy;
	logic [2:0] kind;
	logic [2:0] port;
	logic       acc_ok;
	logic       cell_wr [2];

	function automatic logic [7:0] pmask(input logic [2:0] p);
		pmask = (p == 3'(pdm_pkg::PD)) ? pdm_pkg::D_MASK : 8'hff;
	endfunction

	function automatic logic [7:0] lane(input logic [55:0] v, input int p);
		lane = v[p*pdm_pkg::W +: pdm_pkg::W];
	endfunction

	genvar g;
	generate
		for (g = 0; g < pdm_pkg::PORTS; g++) begin : g_sync
			pdm_sync u_sync (
				.core_clk(core_clk),
				.sys_rst (sys_rst),
				.d       (lane(pin_in, g)),
				.q       (sy[g])
			);
			assign pins_sync[g*pdm_pkg::W +: pdm_pkg::W] = sy[g];
		end
		for (g = 0; g < 2; g++) begin : g_cell
			pdm_cells u_cells (
				.core_clk(core_clk),
				.sys_rst (sys_rst),
				.wr_en   (cell_wr[g]),
				.wr_data (reg_wdata),
				.blk     (blk_r[g]),
				.logic_d ((g == 0) ? bank_a_cells_d : bank_b_cells_d),
				.logic_en(cell_clk_en),
				.q       (cell_q[g])
			);
		end
	endgenerate

	pdm_sync u_sel (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.d       ({7'h00, chip_sel_n_in}),
		.q       (sel_sy)
	);

	assign kind   = reg_addr[pdm_pkg::KIND_MSB:pdm_pkg::KIND_LSB];
	assign port   = reg_addr[pdm_pkg::PORT_MSB:0];
	// select high shuts only the register block; pins and cells keep running
	assign acc_ok = reg_cs && !sel_sy[0];
	assign bank_cells = {cell_q[1], cell_q[0]};
	assign input_cell_bus = {icl_r[2], icl_r[1], icl_r[0]};

	always_comb begin
		for (int i = 0; i < 2; i++)
			cell_wr[i] = acc_ok && reg_wr && kind == pdm_pkg::K_CELL
				&& port == 3'(i);
	end

	// drive selection per port
	always_comb begin
		for (int i = 0; i < pdm_pkg::PORTS; i++) begin
			drv[i] = dir_r[i] & pmask(3'(i));
			val[i] = out_r[i];
		end
		// logic output enables force drive on A,B,C,F
		drv[pdm_pkg::PA] = drv[pdm_pkg::PA] | lane({24'h0, logic_oe}, 0);
		drv[pdm_pkg::PB] = drv[pdm_pkg::PB] | lane({24'h0, logic_oe}, 1);
		drv[pdm_pkg::PC] = drv[pdm_pkg::PC] | lane({24'h0, logic_oe}, 2);
		drv[pdm_pkg::PF] = drv[pdm_pkg::PF] | lane({24'h0, logic_oe}, 3);
		if (mode_r[pdm_pkg::PA][pdm_pkg::M_ALT])
			val[pdm_pkg::PA] = cell_q[0];
		if (mode_r[pdm_pkg::PB][pdm_pkg::M_ALT])
			val[pdm_pkg::PB] = cell_q[1];
		if (mode_r[pdm_pkg::PC][pdm_pkg::M_ALT])
			val[pdm_pkg::PC] = external_select_outputs;
		if (mode_r[pdm_pkg::PF][pdm_pkg::M_ALT])
			val[pdm_pkg::PF] = external_select_outputs;
		for (int i = pdm_pkg::PE; i <= pdm_pkg::PG; i++) begin
			if (mode_r[i][pdm_pkg::M_ADDR]) begin
				val[i] = (i == pdm_pkg::PF) ? addr_latch_lo : addr_latch_hi;
				drv[i] = 8'hff;
			end
		end
		if (mode_r[pdm_pkg::PF][pdm_pkg::M_PERIPH]) begin
			val[pdm_pkg::PF] = periph_data;
			drv[pdm_pkg::PF] = {8{periph_sel}};
		end
		// data port: F low byte, G high byte
		for (int i = pdm_pkg::PF; i <= pdm_pkg::PG; i++) begin
			if (mode_r[i][pdm_pkg::M_DATA]) begin
				val[i] = lane({40'h0, data_bus_out}, i - pdm_pkg::PF);
				drv[i] = {8{data_bus_oe}};
				if (mode_r[i][pdm_pkg::M_RSTPAT] && mcu_reset) begin
					val[i] = lane({40'h0, reset_pattern}, i - pdm_pkg::PF);
					drv[i] = 8'hff;
				end
			end
		end
		if (jtag_active) begin
			val[pdm_pkg::PE] = jtag_out;
			drv[pdm_pkg::PE] = jtag_oe;
		end
		// open drain: drive low only; high is released to the pull-up
		for (int i = 0; i < pdm_pkg::PORTS; i++) begin
			if (mode_r[i][pdm_pkg::M_OD] && !(i == pdm_pkg::PE && jtag_active)) begin
				drv[i] = drv[i] & ~val[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < pdm_pkg::PORTS; i++) begin
			pin_out[i*pdm_pkg::W +: pdm_pkg::W] = val[i];
			pin_oe[i*pdm_pkg::W +: pdm_pkg::W]  = drv[i];
		end
	end

	// register writes and input cell latching
	always_comb begin
		for (int i = 0; i < pdm_pkg::PORTS; i++) begin
			out_nxt[i]  = out_r[i];
			dir_nxt[i]  = dir_r[i];
			mode_nxt[i] = mode_r[i];
			if (acc_ok && reg_wr && port == 3'(i)) begin
				case (kind)
					pdm_pkg::K_OUT:  out_nxt[i]  = reg_wdata & pmask(3'(i));
					pdm_pkg::K_DIR:  dir_nxt[i]  = reg_wdata & pmask(3'(i));
					pdm_pkg::K_MODE: mode_nxt[i] = reg_wdata;
					default:         out_nxt[i]  = out_r[i];
				endcase
			end
		end
		for (int i = 0; i < 2; i++) begin
			blk_nxt[i] = blk_r[i];
			if (acc_ok && reg_wr && kind == pdm_pkg::K_BLK && port == 3'(i))
				blk_nxt[i] = reg_wdata;
		end
		for (int i = 0; i < 3; i++)
			icl_nxt[i] = (icl_r[i] & ~input_cell_le) | (sy[i] & input_cell_le);
	end

	// read mux
	always_comb begin
		rdata_nxt = pdm_pkg::ZERO8;
		case (kind)
			pdm_pkg::K_PIN:  rdata_nxt = (port < 3'(pdm_pkg::PORTS)) ? sy[port] & pmask(port)
				: pdm_pkg::ZERO8;
			pdm_pkg::K_OUT:  rdata_nxt = (port < 3'(pdm_pkg::PORTS)) ? out_r[port]
				: pdm_pkg::ZERO8;
			pdm_pkg::K_CELL: rdata_nxt = (port <= 3'(pdm_pkg::PB)) ? cell_q[port[0]]
				: pdm_pkg::ZERO8;
			pdm_pkg::K_BLK:  rdata_nxt = (port <= 3'(pdm_pkg::PB)) ? blk_r[port[0]]
				: pdm_pkg::ZERO8;
			pdm_pkg::K_ICL:  rdata_nxt = (port <= 3'(pdm_pkg::PC)) ? icl_r[port[1:0]]
				: pdm_pkg::ZERO8;
			pdm_pkg::K_DRV:  rdata_nxt = (port <= 3'(pdm_pkg::PC) || port == 3'(pdm_pkg::PF))
				? drv[port] : pdm_pkg::ZERO8;
			pdm_pkg::K_DIR:  rdata_nxt = (port < 3'(pdm_pkg::PORTS)) ? dir_r[port]
				: pdm_pkg::ZERO8;
			pdm_pkg::K_MODE: rdata_nxt = (port < 3'(pdm_pkg::PORTS)) ? mode_r[port]
				: pdm_pkg::ZERO8;
			default:         rdata_nxt = pdm_pkg::ZERO8;
		endcase
		if (!(acc_ok && reg_rd))
			rdata_nxt = reg_rdata;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < pdm_pkg::PORTS; i++) begin
				out_r[i]  <= pdm_pkg::ZERO8;
				dir_r[i]  <= pdm_pkg::ZERO8;
				mode_r[i] <= pdm_pkg::ZERO8;
			end
			for (int i = 0; i < 2; i++)
				blk_r[i] <= pdm_pkg::BLK_RST;
			for (int i = 0; i < 3; i++)
				icl_r[i] <= pdm_pkg::ZERO8;
			reg_rdata <= pdm_pkg::ZERO8;
		end else begin
			out_r     <= out_nxt;
			dir_r     <= dir_nxt;
			mode_r    <= mode_nxt;
			blk_r     <= blk_nxt;
			icl_r     <= icl_nxt;
			reg_rdata <= rdata_nxt;
		end
	end
endmodule // pdm_ports
`default_nettype wire

// *** rtl/pdm_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pdm_sync (
	input  wire logic       core_clk, // clock
	input  wire logic       sys_rst,  // async reset
	input  wire logic [7:0] d,        // async pins
	output logic      [7:0] q         // synchronised
);
	logic [7:0] s1_r;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= 8'h00;
			q    <= 8'h00;
		end else begin
			s1_r <= d;
			q    <= s1_r;
		end
	end
endmodule // pdm_sync
`default_nettype wire

// *** testbench/pdm_mcu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pdm_mcu_model (
	input  wire logic       core_clk,  // clock
	output logic            reg_cs,    // select
	output logic            reg_wr,    // write strobe
	output logic            reg_rd,    // read strobe
	output logic      [7:0] reg_addr,  // offset
	output logic      [7:0] reg_wdata, // write data
	input  wire logic [7:0] reg_rdata  // read data
);
	initial begin
		{reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	end
	// one ordinary bus cycle; released bus shows inverted leftovers, never stale values
	task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge core_clk);
		#1;
		{reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, w, !w, a, d};
		@(posedge core_clk);
		#1;
		q = reg_rdata;
		{reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h0, ~a, ~d};
	endtask
endmodule // pdm_mcu_model
`default_nettype wire

// *** testbench/pdm_ports_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module pdm_ports_chk (
	input wire logic        core_clk,       // clock
	input wire logic        sys_rst,        // reset
	input wire logic        reg_cs,         // select
	input wire logic        reg_wr,         // write
	input wire logic        reg_rd,         // read
	input wire logic [7:0]  reg_addr,       // offset
	input wire logic [7:0]  reg_rdata,      // read data
	input wire logic        chip_sel_n_in,  // select pin
	input wire logic [55:0] pin_in,         // pins
	input wire logic [55:0] pin_oe,         // enables
	input wire logic [31:0] logic_oe,       // logic enables
	input wire logic [7:0]  bank_a_cells_d, // bank a next
	input wire logic [7:0]  bank_b_cells_d, // bank b next
	input wire logic        cell_clk_en,    // cell enable
	input wire logic [7:0]  input_cell_le,  // latch enable
	input wire logic [23:0] input_cell_bus, // input cells
	input wire logic [55:0] pins_sync,      // synced pins
	input wire logic [15:0] bank_cells      // cells
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] seln_q;
	// select pin passes a 2-ff sync, so demand a settled level
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) seln_q <= 3'h0;
		else seln_q <= {seln_q[1:0], chip_sel_n_in};
	end
	wire sel_ok = (seln_q == 3'h0) && !chip_sel_n_in;
	wire sel_off = (seln_q == 3'h7) && chip_sel_n_in;
	wire rd = reg_cs && reg_rd;
	chk_rd_holds: assert property (!rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	chk_blk_rd: assert property (rd && sel_off |=> $stable(reg_rdata))
		else $error("read answered while deselected");
	chk_unmap_rd: assert property (rd && sel_ok && reg_addr == 8'h22 |=> reg_rdata == 8'h00)
		else $error("unmapped cell read not zero");
	chk_d_upper: assert property (rd && sel_ok && reg_addr[2:0] == 3'h3
		&& reg_addr[6:5] == 2'h0 |=> reg_rdata[7:4] == 4'h0)
		else $error("port d upper bits not zero");
	chk_d_no_oe: assert property (pin_oe[31:28] == 4'h0)
		else $error("missing port d pin driven");
	chk_lgc_force: assert property (logic_oe[16] && $past(logic_oe[16]) |-> pin_oe[16])
		else $error("logic enable did not force drive");
	chk_pin_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
		|-> pins_sync == $past(pin_in, 2))
		else $error("pin sync latency wrong");
	chk_cell_hold: assert property (!cell_clk_en && !reg_wr |=> $stable(bank_cells))
		else $error("cells changed without load");
	chk_cell_load: assert property (cell_clk_en && !reg_wr
		|=> bank_cells == $past({bank_b_cells_d, bank_a_cells_d}))
		else $error("cells did not take logic value");
	chk_icl_hold: assert property (!input_cell_le[0] |=> $stable(input_cell_bus[0]))
		else $error("input cell moved while closed");
	cov_rd: cover property (rd && sel_ok);
	cov_blk: cover property (rd && sel_off);
	cov_load: cover property (cell_clk_en);
endmodule // pdm_ports_chk
bind pdm_ports pdm_ports_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_cs(reg_cs),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.chip_sel_n_in(chip_sel_n_in), .pin_in(pin_in), .pin_oe(pin_oe), .logic_oe(logic_oe),
	.bank_a_cells_d(bank_a_cells_d), .bank_b_cells_d(bank_b_cells_d), .cell_clk_en(cell_clk_en),
	.input_cell_le(input_cell_le), .input_cell_bus(input_cell_bus), .pins_sync(pins_sync),
	.bank_cells(bank_cells));
`default_nettype wire

// *** testbench/test_pdm_ports.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_pdm_ports;
	logic        core_clk, sys_rst, reg_cs, reg_wr, reg_rd, chip_sel_n_in, cell_clk_en;
	logic        data_bus_oe, periph_sel, mcu_reset, jtag_active;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, bank_a_cells_d, bank_b_cells_d, input_cell_le;
	logic [7:0]  external_select_outputs, addr_latch_lo, addr_latch_hi, periph_data;
	logic [7:0]  jtag_out, jtag_oe, q;
	logic [15:0] data_bus_out, reset_pattern, bank_cells;
	logic [23:0] input_cell_bus;
	logic [31:0] logic_oe;
	logic [55:0] pin_in, pin_out, pin_oe, pins_sync;
	int          fails = 0, n_tests = 0, cyc = 0;
	pdm_mcu_model u_mcu (.core_clk(core_clk), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	pdm_ports u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_cs(reg_cs), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.chip_sel_n_in(chip_sel_n_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.bank_a_cells_d(bank_a_cells_d), .bank_b_cells_d(bank_b_cells_d),
		.cell_clk_en(cell_clk_en), .input_cell_le(input_cell_le), .logic_oe(logic_oe),
		.external_select_outputs(external_select_outputs), .addr_latch_lo(addr_latch_lo),
		.addr_latch_hi(addr_latch_hi), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.periph_sel(periph_sel), .periph_data(periph_data), .mcu_reset(mcu_reset),
		.reset_pattern(reset_pattern), .jtag_active(jtag_active), .jtag_out(jtag_out),
		.jtag_oe(jtag_oe), .input_cell_bus(input_cell_bus), .pins_sync(pins_sync),
		.bank_cells(bank_cells));
	always #25 core_clk = ~core_clk;
	// the whole run needs about 120 cycles
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_mcu.cyc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		u_mcu.cyc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic t_out();
		wr(8'h10, 8'h55);
		wr(8'h60, 8'hff);
		chk(pin_out[7:0], 8'h55);
		chk(pin_oe[7:0], 8'hff);
		rd(8'h10, 8'h55);
		wr(8'h60, 8'h00);
		chk(pin_oe[7:0], 8'h00);
		rd(8'h50, 8'h00);
		logic_oe[23:16] = 8'h0f;
		wr(8'h12, 8'h3c);
		chk(pin_oe[23:16], 8'h0f);
		chk(pin_out[23:16], 8'h3c);
		rd(8'h52, 8'h0f);
		logic_oe = '0;
	endtask
	task automatic t_pin();
		pin_in[15:8] = 8'ha5;
		pin_in[31:24] = 8'hff;
		wait_n(3);
		rd(8'h01, 8'ha5);
		rd(8'h03, 8'h0f);
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h0f);
		wr(8'h63, 8'hff);
		chk(pin_oe[31:24], 8'h0f);
		rd(8'h63, 8'h0f);
		rd(8'h23, 8'h00);
	endtask
	task automatic t_cells();
		rd(8'h30, 8'h00);
		wr(8'h30, 8'hf0);
		rd(8'h30, 8'hf0);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h0f);
		chk(bank_cells[7:0], 8'h0f);
		{bank_b_cells_d, bank_a_cells_d, cell_clk_en} = {8'h81, 8'h0f, 1'b1};
		wait_n(1);
		cell_clk_en = 1'b0;
		chk(bank_cells[15:8], 8'h81);
		rd(8'h21, 8'h81);
		rd(8'h22, 8'h00);
	endtask
	task automatic t_icl();
		pin_in[23:16] = 8'h96;
		input_cell_le = 8'hff;
		wait_n(4);
		rd(8'h42, 8'h96);
		chk(input_cell_bus[23:16], 8'h96);
		input_cell_le = 8'h00;
		pin_in[23:16] = 8'h11;
		wait_n(4);
		rd(8'h42, 8'h96);
		rd(8'h43, 8'h00);
	endtask
	task automatic t_sel();
		rd(8'h10, 8'h55);
		chip_sel_n_in = 1'b1;
		wait_n(3);
		wr(8'h10, 8'h11);
		rd(8'h00, 8'h55);
		chk(pin_out[7:0], 8'h55);
		chip_sel_n_in = 1'b0;
		wait_n(3);
		rd(8'h10, 8'h55);
	endtask
	task automatic t_jtag();
		{jtag_active, jtag_out, jtag_oe} = {1'b1, 8'h5a, 8'hff};
		wait_n(1);
		chk(pin_out[39:32], 8'h5a);
		chk(pin_oe[39:32], 8'hff);
		jtag_active = 1'b0;
	endtask
	// alternate pin roles: inputs are set before the mode write so pins settle
	task automatic t_modes();
		wr(8'h60, 8'hff);
		wr(8'h70, 8'h01);
		chk(pin_oe[7:0], 8'haa);
		rd(8'h50, 8'haa);
		wr(8'h70, 8'h00);
		wr(8'h60, 8'h00);
		wr(8'h71, 8'h02);
		chk(pin_out[15:8], 8'h81);
		{addr_latch_lo, periph_data, periph_sel} = {8'h12, 8'h6b, 1'b1};
		wr(8'h75, 8'h40);
		chk(pin_out[47:40], 8'h12);
		chk(pin_oe[47:40], 8'hff);
		wr(8'h75, 8'h08);
		chk(pin_out[47:40], 8'h6b);
		rd(8'h55, 8'hff);
		periph_sel = 1'b0;
		wait_n(1);
		chk(pin_oe[47:40], 8'h00);
		{data_bus_out, data_bus_oe, reset_pattern} = {16'hbeef, 1'b1, 16'h1234};
		wr(8'h75, 8'h04);
		wr(8'h76, 8'h04);
		chk(pin_out[47:40], 8'hef);
		chk(pin_out[55:48], 8'hbe);
		mcu_reset = 1'b1;
		wr(8'h75, 8'h14);
		wr(8'h76, 8'h14);
		chk(pin_out[47:40], 8'h34);
		chk(pin_out[55:48], 8'h12);
		chk(pin_oe[55:48], 8'hff);
		mcu_reset = 1'b0;
		wr(8'h75, 8'h00);
		wr(8'h76, 8'h00);
		wr(8'h71, 8'h00);
	endtask
	initial begin
		{core_clk, sys_rst, chip_sel_n_in, cell_clk_en, data_bus_oe} = 5'h08;
		{periph_sel, mcu_reset, jtag_active, bank_a_cells_d, bank_b_cells_d, input_cell_le} = '0;
		{external_select_outputs, addr_latch_lo, addr_latch_hi, periph_data} = '0;
		{jtag_out, jtag_oe, data_bus_out, reset_pattern, logic_oe} = '0;
		pin_in = 56'h00_0000_0000_00aa;
		wait_n(8);
		sys_rst = 1'b0;
		t_out();
		t_pin();
		t_cells();
		t_icl();
		t_sel();
		t_jtag();
		t_modes();
		stop_test();
	end
endmodule // test_pdm_ports
`default_nettype wire
